//--- hw/apr_map.svh
`ifndef APR_MAP_SVH
`define APR_MAP_SVH

// ------------------------------------------------------------
// Clock period in ns; decimation and strobe timing in clock cycles
// ------------------------------------------------------------
`define APR_CLK_PERIOD_NS 40
`define APR_OSR           6'h20
`define APR_HALF          6'h10

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define APR_ADDR_CTRL   8'h00
`define APR_ADDR_STATUS 8'h04
`define APR_ADDR_MASK   8'h08
`define APR_ADDR_WORD   8'h0c
`define APR_ADDR_STATE  8'h10

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define APR_CTRL_BUF_EN  0
`define APR_CTRL_SW_PD   1
`define APR_EV_WORD      0
`define APR_EV_RANGE     1
`define APR_EV_BURST     2
`define APR_CTRL_RESET   2'h1
`define APR_MASK_RESET   3'h0
`define APR_RESP_OKAY    2'h0
`define APR_RESP_SLVERR  2'h2

`endif

//--- hw/apr_pkg.sv
package apr_pkg;

    // Readout sequencer states
    typedef enum logic [1:0] {
        APR_SKIP,
        APR_STREAM,
        APR_FILL,
        APR_PULSE
    } apr_state_type;

endpackage

//--- hw/apr_mem_if.sv
`timescale 1ns/10ps
`default_nettype none

// Write and read port of the output buffer memory
interface apr_mem_if #(
    parameter int W  = 19,
    parameter int AW = 4
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0]  wr_data;
    logic [AW-1:0] rd_addr;
    logic [W-1:0]  rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

`default_nettype wire

//--- hw/apr_buffer_mem.sv
`timescale 1ns/10ps
`default_nettype none

module apr_buffer_mem #(
    parameter int W  = 19,
    parameter int AW = 4
) (
    input  wire logic aclk,
    apr_mem_if.mem    port
);
    logic [W-1:0] store [0:(1<<AW)-1];

    // Write side, no reset needed for data
    always_ff @(posedge aclk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge aclk) begin
        port.rd_data <= store[port.rd_addr];
    end
endmodule

`default_nettype wire

//--- hw/apr_readout.sv
// Behaviour
// - Falling edge of sample_valid_n announces a new result.
// - Result sits on an 18-bit bus, bit 17 most significant.
// - Buffer off: strobe is a square wave, 16 cycles high, 16 low.
// - Strobe changes only on rising clock edges.
// - Buffer off: bus takes the new word at each falling strobe edge.
// - Bus floats while select or read is high; driven when both low unless powered down out of reset.
// - Bus drive starts once the later of select and read falls.
// - In reset: filter cleared, strobe held high, bus bits low.
// - over_range_flag high while the input exceeds the range.
// - power_down_n low stops the readout path; AXI registers and vref_enable keep working; default is running.
// - onchip_vref_select_n low enables the on-chip reference.
// - Three depth pins, bit 2 most significant, set buffer level.
// - Buffer on: each strobe announces level words, read by pulses.
// - One output word every 32 clock cycles.
// - Buffer on: strobe pulses high one cycle per burst.
// - Buffer on: first strobe low 32 times level plus one after reset.
`timescale 1ns/10ps
`default_nettype none
`include "apr_map.svh"

module apr_readout #(
    parameter int DW = 18,
    parameter int LW = 3,
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [DW-1:0] filter_word,
    input  wire logic          filter_over_range,
    input  wire logic          chip_select_n,
    input  wire logic          read_n,
    input  wire logic          power_down_n,
    input  wire logic          onchip_vref_select_n,
    input  wire logic [LW-1:0] buffer_depth_select,
    output logic               sample_valid_n,
    output logic [DW-1:0]      sample_bus_out,
    output logic               sample_bus_oe,
    output logic               over_range_flag,
    output logic               vref_enable,
    output logic               irq,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);
    localparam int MW = DW + 1;
    localparam int BA = LW + 1;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [LW+3:0] pin_s1;
    logic [LW+3:0] pin_s2;
    logic          rd_s3;
    logic          cs_s2;
    logic          rd_s2;
    logic          pd_pin_s2;
    logic          vref_s2;
    logic [LW-1:0] depth_s2;

    // Two flops on every pin; no reset so reset sees live pins
    always_ff @(posedge aclk) begin
        pin_s1 <= {buffer_depth_select, onchip_vref_select_n,
                   power_down_n, read_n, chip_select_n};
        pin_s2 <= pin_s1;
        rd_s3  <= pin_s2[1];
    end

    assign cs_s2     = pin_s2[0];
    assign rd_s2     = pin_s2[1];
    assign pd_pin_s2 = pin_s2[2];
    assign vref_s2   = pin_s2[3];
    assign depth_s2  = pin_s2[LW+3:4];

    // ------------------------------------------------------------
    // Registers and derived controls
    // ------------------------------------------------------------
    logic [1:0]          ctrl;
    logic [2:0]          status;
    logic [2:0]          mask;
    logic                pd;
    logic [LW-1:0]       sel_level;
    logic [5:0]          phase;
    logic                word_tick;
    apr_pkg::apr_state_type state;
    logic [LW-1:0]       level;
    logic [LW-1:0]       wr_cnt;
    logic [LW-1:0]       rd_ptr;
    logic                wr_bank;
    logic                rd_bank;
    logic                rd_pulse;
    logic [2:0]          ev;
    logic                burst_seen;

    // Pin low or software bit both power the block down
    // power down
    assign pd = !pd_pin_s2 || ctrl[`APR_CTRL_SW_PD];
    assign sel_level = ctrl[`APR_CTRL_BUF_EN] ? depth_s2 : '0;
    assign word_tick = (phase == `APR_OSR - 6'h1);
    // Rising edge of read strobe while selected advances the burst
    // burst read
    assign rd_pulse = rd_s2 && !rd_s3 && !cs_s2;

    // ------------------------------------------------------------
    // Buffer memory, two banks so filling overlaps reading
    // ------------------------------------------------------------
    apr_mem_if #(.W(MW), .AW(BA)) mem_port ();

    apr_buffer_mem #(.W(MW), .AW(BA)) i_apr_buffer_mem (
        .aclk (aclk),
        .port (mem_port)
    );

    assign mem_port.wr_en   = (state == apr_pkg::APR_FILL) && word_tick
                              && !pd;
    assign mem_port.wr_addr = {wr_bank, wr_cnt};
    assign mem_port.wr_data = {filter_over_range, filter_word};
    assign mem_port.rd_addr = {rd_bank, rd_ptr};

    // ------------------------------------------------------------
    // Decimation phase
    // ------------------------------------------------------------
    // word every 32
    always_ff @(posedge aclk) begin
        if (!aresetn || pd) begin
            phase <= '0;
        end else if (word_tick) begin
            phase <= '0;
        end else begin
            phase <= phase + 6'h1;
        end
    end

    // ------------------------------------------------------------
    // Readout sequencer
    // ------------------------------------------------------------
    // First word after reset is dropped while the filter settles
    // first burst
    always_ff @(posedge aclk) begin
        if (!aresetn || pd) begin
            state   <= apr_pkg::APR_SKIP;
            level   <= '0;
            wr_cnt  <= '0;
            wr_bank <= 1'b0;
        end else begin
            case (state)
                apr_pkg::APR_SKIP: begin
                    if (word_tick) begin
                        level <= sel_level;
                        state <= (sel_level == '0) ? apr_pkg::APR_STREAM
                                                   : apr_pkg::APR_FILL;
                    end
                end
                apr_pkg::APR_STREAM: begin
                    if (word_tick && sel_level != '0) begin
                        level <= sel_level;
                        state <= apr_pkg::APR_FILL;
                    end
                end
                apr_pkg::APR_FILL: begin
                    if (word_tick) begin
                        if (wr_cnt == level - LW'(1)) begin
                            wr_cnt <= '0;
                            state  <= apr_pkg::APR_PULSE;
                        end else begin
                            wr_cnt <= wr_cnt + LW'(1);
                        end
                    end
                end
                apr_pkg::APR_PULSE: begin
                    wr_bank <= !wr_bank;
                    level   <= sel_level;
                    state   <= (sel_level == '0) ? apr_pkg::APR_STREAM
                                                 : apr_pkg::APR_FILL;
                end
                default: state <= apr_pkg::APR_SKIP;
            endcase
        end
    end

    // With the buffer on, the strobe stays high until the first burst is announced
    // first burst
    always_ff @(posedge aclk) begin
        if (!aresetn || pd) begin
            burst_seen <= 1'b0;
        end else if (state == apr_pkg::APR_PULSE) begin
            burst_seen <= 1'b1;
        end
    end

    // Read pointer walks the bank just filled
    always_ff @(posedge aclk) begin
        if (!aresetn || pd) begin
            rd_ptr  <= '0;
            rd_bank <= 1'b0;
        end else if (state == apr_pkg::APR_PULSE) begin
            rd_ptr  <= '0;
            rd_bank <= wr_bank;
        end else if (rd_pulse && rd_ptr != level - LW'(1)) begin
            rd_ptr <= rd_ptr + LW'(1);
        end
    end

    // ------------------------------------------------------------
    // Strobe, bus and flag outputs
    // ------------------------------------------------------------
    // falling strobe
    always_ff @(posedge aclk) begin
        if (!aresetn || pd) begin
            sample_valid_n <= 1'b1;
        end else if (state == apr_pkg::APR_STREAM) begin
            if (word_tick) begin
                sample_valid_n <= 1'b0;
            end else if (phase == `APR_HALF - 6'h1) begin
                sample_valid_n <= 1'b1;
            end
        end else if (state == apr_pkg::APR_PULSE) begin
            sample_valid_n <= 1'b1;
        end else if (state == apr_pkg::APR_FILL && burst_seen) begin
            sample_valid_n <= 1'b0;
        end
    end

    // Word and flag load together; buffer path trails the pointer
    // bus order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_bus_out  <= '0;
            over_range_flag <= 1'b0;
        end else if (pd) begin
            over_range_flag <= 1'b0;
        end else if (state == apr_pkg::APR_STREAM) begin
            if (word_tick) begin
                sample_bus_out  <= filter_word;
                over_range_flag <= filter_over_range;
            end
        end else if (state != apr_pkg::APR_SKIP) begin
            sample_bus_out  <= mem_port.rd_data[DW-1:0];
            over_range_flag <= mem_port.rd_data[DW];
        end
    end

    // Drive only while both select and read are low
    // bus float
    always_ff @(posedge aclk) begin
        sample_bus_oe <= !cs_s2 && !rd_s2 && (!pd || !aresetn);
    end

    always_ff @(posedge aclk) begin
        vref_enable <= !vref_s2;
    end

    // ------------------------------------------------------------
    // Events, status, interrupt
    // ------------------------------------------------------------
    logic rd_status;

    always_comb begin
        ev = '0;
        ev[`APR_EV_WORD]  = word_tick && !pd &&
                            (state == apr_pkg::APR_STREAM ||
                             state == apr_pkg::APR_FILL);
        ev[`APR_EV_RANGE] = ev[`APR_EV_WORD] && filter_over_range;
        ev[`APR_EV_BURST] = (state == apr_pkg::APR_PULSE);
    end

    // Read clears, but a same-cycle event still lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
        end else begin
            status <= (rd_status ? 3'h0 : status) | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic          aw_held;
    logic          w_held;
    logic [AW-1:0] aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          do_write;
    logic          ar_take;
    logic [31:0]   rd_mux;
    logic          rd_hit;

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                                input logic [31:0] nw,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign do_write  = aw_held && w_held && !s_axi_bvalid;
    assign ar_take   = s_axi_arvalid && s_axi_arready;
    assign rd_status = ar_take && s_axi_araddr == `APR_ADDR_STATUS;

    // Address and data accepted in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
        end
    end

    // Register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl         <= `APR_CTRL_RESET;
            mask         <= `APR_MASK_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `APR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `APR_RESP_OKAY;
            case (aw_addr)
                `APR_ADDR_CTRL:
                    ctrl <= 2'(merge_lanes(32'(ctrl), w_data, w_strb));
                `APR_ADDR_MASK:
                    mask <= 3'(merge_lanes(32'(mask), w_data, w_strb));
                `APR_ADDR_STATUS, `APR_ADDR_WORD, `APR_ADDR_STATE: ;
                default: s_axi_bresp <= `APR_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `APR_ADDR_CTRL:   rd_mux = 32'(ctrl);
            `APR_ADDR_STATUS: rd_mux = 32'(status);
            `APR_ADDR_MASK:   rd_mux = 32'(mask);
            `APR_ADDR_WORD:   rd_mux = 32'({over_range_flag,
                                            sample_bus_out});
            `APR_ADDR_STATE:  rd_mux = 32'({level, rd_ptr, pd,
                                            sample_valid_n});
            default:          rd_hit = 1'b0;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `APR_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `APR_RESP_OKAY
                                       : `APR_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_low_half: assert property (
        disable iff (!aresetn || pd)
        $fell(sample_valid_n) && state == apr_pkg::APR_STREAM && !pd
        ##1 (!pd)[*8] |-> (!sample_valid_n)[*8]
    ) else $error("strobe low half too short");
    chk_word_period: assert property (
        disable iff (!aresetn || pd)
        word_tick && !pd ##1 !pd |-> ##31 word_tick
    ) else $error("word period not 32 cycles");
    chk_word_load: assert property (
        $fell(sample_valid_n) && $past(state) == apr_pkg::APR_STREAM
        |-> sample_bus_out == $past(filter_word)
    ) else $error("bus not loaded at strobe fall");
    chk_range_pair: assert property (
        $fell(sample_valid_n) && $past(state) == apr_pkg::APR_STREAM
        |-> over_range_flag == $past(filter_over_range)
    ) else $error("range flag not with its word");
    chk_bus_float: assert property (
        cs_s2 || rd_s2 |=> !sample_bus_oe
    ) else $error("bus driven while deselected");
    chk_bus_drive: assert property (
        !cs_s2 && !rd_s2 && !pd |=> sample_bus_oe
    ) else $error("bus not driven when selected");
    chk_burst_pulse: assert property (
        disable iff (!aresetn || pd)
        state == apr_pkg::APR_PULSE && sel_level != '0
        |=> sample_valid_n ##1 !sample_valid_n
    ) else $error("burst pulse missing");
    chk_pd_quiet: assert property (
        pd |=> sample_valid_n && !sample_bus_oe
    ) else $error("activity during power down");
    chk_vref_follow: assert property (
        ##1 vref_enable == !$past(vref_s2)
    ) else $error("reference enable wrong");
    chk_reset_outputs: assert property (@(posedge aclk)
        disable iff (1'b0)
        !aresetn |=> sample_valid_n && sample_bus_out == '0
    ) else $error("reset outputs wrong");

    cov_stream_word: cover property ($fell(sample_valid_n) &&
                                     state == apr_pkg::APR_STREAM);
    cov_burst: cover property (state == apr_pkg::APR_PULSE);
    cov_read_step: cover property (rd_pulse && rd_ptr != '0);
    cov_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

//--- tb/apr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Host reading the parallel sample port
// ------------------------------------------------------------
module apr_host_model (
    input  wire logic aclk,
    input  wire logic hold_low,
    input  wire logic pulse_en,
    output logic      chip_select_n,
    output logic      read_n
);
    logic [2:0] cnt = 3'h0;

    // select and read strobes
    // Pulses of 4 clocks each side clear the 2-FF input path
    always_ff @(posedge aclk) begin
        cnt <= cnt + 3'h1;
        chip_select_n <= !(hold_low || pulse_en);
        read_n <= hold_low ? 1'b0 : (pulse_en ? cnt[2] : 1'b1);
    end
endmodule

`default_nettype wire

//--- tb/apr_readout_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "apr_map.svh"

module apr_readout_tb;
    logic        aclk, aresetn, filter_over_range, chip_select_n, read_n;
    logic        power_down_n, onchip_vref_select_n, hold_low, pulse_en;
    logic [17:0] filter_word, sample_bus_out, sample_bus, last_bus;
    logic [2:0]  buffer_depth_select;
    logic        sample_valid_n, sample_bus_oe, over_range_flag;
    logic        vref_enable, irq, prv;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          num_errors, samples_checked, cycles, n;

    apr_readout #(.DW(18), .LW(3), .AW(8)) i_apr_readout (
        .aclk, .aresetn, .filter_word, .filter_over_range, .chip_select_n,
        .read_n, .power_down_n, .onchip_vref_select_n, .buffer_depth_select,
        .sample_valid_n, .sample_bus_out, .sample_bus_oe, .over_range_flag,
        .vref_enable, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    apr_host_model i_apr_host_model (
        .aclk, .hold_low, .pulse_en, .chip_select_n, .read_n);

    // Released bus shows the inverse, so stale data never matches
    always @(posedge aclk) if (sample_bus_oe) last_bus <= sample_bus_out;
    assign sample_bus = sample_bus_oe ? sample_bus_out : ~last_bus;

    task test_done;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Ends once s_axi_bvalid is seen; the run ceiling catches a hang
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            rsp = s_axi_bresp;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
    endtask

    // Strobe edges, seen at sampling edges
    task wait_edge(input logic to);
        prv = sample_valid_n;
        repeat (300) begin
            @(posedge aclk);
            if (prv !== to && sample_valid_n === to) break;
            prv = sample_valid_n;
        end
    endtask

    task measure(input logic lvl);
        n = 0;
        do begin
            n++;
            @(posedge aclk);
        end while (sample_valid_n === lvl && n < 300);
    endtask

    task t_stream;
        wait_edge(1'b0);
        wait_edge(1'b0);
        chk(sample_bus, 18'h2a5c3);
        chk(over_range_flag, 1'b1);
        measure(1'b0);
        chk(n, 16);
        measure(1'b1);
        chk(n, 16);
        // settle: filter input is constant, so early words compare
        filter_over_range <= 1'b0;
        wait_edge(1'b0);
        chk(over_range_flag, 1'b0);
        filter_over_range <= 1'b1;
        $display("stream done");
    endtask

    task t_float;
        hold_low <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(sample_bus_oe, 1'b0);
        hold_low <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(sample_bus_oe, 1'b1);
        $display("float done");
    endtask

    task t_regs;
        axr(`APR_ADDR_CTRL);
        chk(rd, 32'h1);
        axr(`APR_ADDR_MASK);
        chk(rd, 32'h0);
        axr(8'h20);
        chk(rsp, `APR_RESP_SLVERR);
        chk(rd, 32'h0);
        axw(8'h20, 32'h0);
        chk(rsp, `APR_RESP_SLVERR);
        axw(`APR_ADDR_MASK, 32'h1);
        chk(rsp, `APR_RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk(irq, 1'b1);
        axw(`APR_ADDR_MASK, 32'h0);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        axr(`APR_ADDR_STATUS);
        chk(rd[0], 1'b1);
        axw(`APR_ADDR_CTRL, 32'h3);
        repeat (40) @(posedge aclk);
        chk({sample_valid_n, sample_bus_oe}, 2'h2);
        axw(`APR_ADDR_CTRL, 32'h1);
        power_down_n <= 1'b0;
        repeat (40) @(posedge aclk);
        chk({sample_valid_n, sample_bus_oe}, 2'h2);
        power_down_n <= 1'b1;
        onchip_vref_select_n <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(vref_enable, 1'b1);
        onchip_vref_select_n <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(vref_enable, 1'b0);
        $display("regs done");
    endtask

    task t_buffer;
        buffer_depth_select <= 3'h2;
        hold_low <= 1'b0;
        pulse_en <= 1'b1;
        wait_edge(1'b1);
        wait_edge(1'b1);
        measure(1'b1);
        chk(n, 1);
        measure(1'b0);
        chk(n, 32 * 2 - 1);
        // Bus floats between read pulses; look only while it is driven
        while (sample_bus_oe !== 1'b1) @(posedge aclk);
        chk(sample_bus, 18'h2a5c3);
        $display("buffer done");
    endtask

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Run ceiling well above the several hundred cycles needed
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done;
        end
    end

    initial begin
        {aresetn, hold_low, pulse_en, last_bus, cycles} = '0;
        {power_down_n, onchip_vref_select_n} = 2'h3;
        {filter_word, filter_over_range} = {18'h2a5c3, 1'b1};
        buffer_depth_select = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
        num_errors = 0;
        samples_checked = 0;
        hold_low <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({sample_valid_n, sample_bus_out}, {1'b1, 18'h0});
        aresetn <= 1'b1;
        t_stream;
        t_float;
        t_regs;
        t_buffer;
        test_done;
    end
endmodule

`default_nettype wire
